// ### include/dtp_pkg.sv
// package: constants for the ds3 transmit payload input port
package dtp_pkg;
   ////////////////////////////////////////////////////////////////////////////
   // register map (byte addresses on apb)
   localparam logic [7:0]  MODE_OFFSET    = 8'h00; // framer operating mode
   localparam logic [7:0]  STATUS_OFFSET  = 8'h04; // frame position and mode status
   localparam logic [7:0]  MODE_RESET     = 8'h00; // loop timed, serial-friendly default
   // operating mode field positions
   localparam int          LOOPBACK_BIT   = 7;     // local loopback
   localparam int          DS3E3_BIT      = 6;     // ds3/e3 select
   localparam int          LOS_EN_BIT     = 5;     // internal los enable
   localparam int          SOFT_RESET_BIT = 4;     // holds the frame counter at the last bit position
   localparam int          IRQ_RESET_BIT  = 3;     // interrupt enable reset
   localparam int          FORMAT_BIT     = 2;     // frame format
   localparam int          TIMSEL_MSB     = 1;     // timing reference select, high bit
   localparam int          TIMSEL_LSB     = 0;     // timing reference select, low bit
   localparam logic [1:0]  TIMSEL_LOOP    = 2'h0;  // loop-timed code
   // status register field positions
   localparam int          ST_POS_MSB     = 12;    // current bit position in frame
   localparam int          ST_LOOP_BIT    = 16;    // loop timing active
   localparam int          ST_NIB_BIT     = 17;    // nibble mode active
   localparam int          ST_SLAVE_BIT   = 18;    // frame slave active
   ////////////////////////////////////////////////////////////////////////////
   // ds3 frame geometry: 56 blocks of one overhead bit and 84 payload bits
   localparam logic [12:0] FRAME_BITS     = 13'h1298; // 4760 bits per frame
   localparam logic [12:0] FRAME_LAST     = 13'h1297; // last bit position
   localparam logic [6:0]  BLOCK_LAST     = 7'h54;    // 85 bits per block
   localparam logic [12:0] PAYLOAD_BITS   = 13'h1260; // 4704 payload bits per frame
   localparam logic [12:0] NIBBLES        = 13'h0498; // 1176 nibbles per frame
   localparam logic [12:0] NIB_LAST_START = 13'h125C; // first payload bit of last nibble
   localparam logic [1:0]  NIB_PHASE_LOW  = 2'h2;     // nibble clock falls here
   // timing
   localparam int          PCLK_HZ        = 10000000; // register clock rate
   localparam int          DS3_CLK_HZ     = 44736000; // 44.736 mhz interface clock
endpackage : dtp_pkg

// ### src/dtp_payload_port.sv
// design: ds3 transmit payload input port with apb mode/status registers
// Functional notes
// R1: six modes: serial/nibble, loop/local, master/slave
// R2: master/slave choice only under local timing
// R3: loop timing uses recovered line clock
// R4: loop timing ignores local clock input
// R5: forward recovered clock on loop clock output
// R6: forwarded clock shared by both parties
// R7: serial capture on forwarded clock rising edge
// R8: far end changes data on rising edge
// R9: frame end high one bit, last bit
// R10: far end restarts frame after frame end
// R11: overhead warning one bit before overhead
// R12: far end delays payload after warning
// R13: serial needs select pin low, code 00; serial_mode here follows the pin alone, under every timing code
// R14: mode register at 0x00, fields from bit 7
// R15: far end avoids loopback when loop timed
// R16: nibble capture on nibble clock rising edge
// R17: 1176 nibble clock edges per frame
// R18: nibble frame end during last nibble
// R19: frame slave restarts on reference rising edge
// R20: bit position counter locates frame end, overhead
// R21: local timing codes are parameters
module dtp_payload_port #(
   parameter logic [1:0] TIMSEL_MASTER = 2'h2, // local-timed frame master code
   parameter logic [1:0] TIMSEL_SLAVE  = 2'h1  // local-timed frame slave code
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        recovered_line_clock_in,
   input  wire logic        local_timing_clock_in,
   input  wire logic        nibble_mode_select_pin,
   input  wire logic        serial_payload_in,
   input  wire logic [3:0]  nibble_payload_in,
   input  wire logic        frame_reference_in,
   output logic             loop_timed_clock_out,
   output logic             frame_end_pulse_out,
   output logic             overhead_warn_out,
   output logic             nibble_clock_out,
   output logic             nibble_frame_end_out,
   output logic             payload_bit_out,
   output logic             payload_valid_out,
   output logic [3:0]       nibble_data_out,
   output logic             nibble_valid_out
);
   ////////////////////////////////////////////////////////////////////////////
   // mode decode

   typedef enum logic [1:0] {
      DTP_LOOP   = 2'b00, // loop timed
      DTP_MASTER = 2'b01, // local timed, frame master
      DTP_SLAVE  = 2'b10, // local timed, frame slave
      DTP_IDLE   = 2'b11  // unused code, no timing reference
   } dtp_timing_t;

   // overhead bit sits at block offset zero
   function automatic logic dtp_is_oh(input logic [6:0] blk);
      dtp_is_oh = (blk == 7'h00);
   endfunction : dtp_is_oh

   logic [7:0]  mode_q;       // framer operating mode register
   dtp_timing_t timing;       // decoded timing reference
   logic        serial_mode;  // serial transfer selected
   logic        nib_mode;     // nibble transfer selected
   logic        soft_rst;     // software reset of the frame counter
   wire  [1:0]  timsel = mode_q[dtp_pkg::TIMSEL_MSB:dtp_pkg::TIMSEL_LSB];

   // master/slave exists only for the local codes; loop code wins first
   always_comb begin // see R1 see R2 see R21
      case (timsel)
         dtp_pkg::TIMSEL_LOOP: timing = DTP_LOOP;
         TIMSEL_MASTER:        timing = DTP_MASTER;
         TIMSEL_SLAVE:         timing = DTP_SLAVE;
         default:              timing = DTP_IDLE;
      endcase
   end

   assign serial_mode = ~nibble_mode_select_pin; // see R13
   assign nib_mode    = nibble_mode_select_pin;
   assign soft_rst    = mode_q[dtp_pkg::SOFT_RESET_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // timing reference selection and bit strobe

   logic line_q;     // line clock level one pclk ago
   logic local_q;    // local clock level one pclk ago
   logic line_rise;  // line clock rising edge
   logic local_rise; // local clock rising edge
   logic bit_strobe; // one pclk per reference rising edge

   // each source keeps its own history: a switch of reference never fakes an edge
   assign line_rise  = recovered_line_clock_in & ~line_q;
   assign local_rise = local_timing_clock_in & ~local_q;
   // local clock edges are never looked at in loop timing
   assign bit_strobe = (timing == DTP_LOOP) ? line_rise : // see R3 see R4
                       (timing == DTP_IDLE) ? 1'b0 : local_rise;

   // clock histories for edge detection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_q  <= 1'b0;
         local_q <= 1'b0;
      end else begin
         line_q  <= recovered_line_clock_in;
         local_q <= local_timing_clock_in;
      end
   end

   // forwarded clock, low outside loop timing; lags the line clock one pclk
   always_ff @(posedge pclk or negedge presetn) begin // see R5 see R6
      if (!presetn) loop_timed_clock_out <= 1'b0;
      else          loop_timed_clock_out <= (timing == DTP_LOOP) & recovered_line_clock_in;
   end

   ////////////////////////////////////////////////////////////////////////////
   // frame position counters

   logic [12:0] pos_q;     // bit position in frame
   logic [6:0]  blk_q;     // bit offset within block
   logic [12:0] pc_q;      // payload bits done in frame
   logic        fref_q;    // frame reference at last strobe
   logic        slave_start; // reference rising edge in slave mode
   logic [12:0] pos_d;
   logic [6:0]  blk_d;
   logic [12:0] pidx;      // index of current payload bit
   logic        is_payload; // current bit carries payload
   logic [1:0]  nphase;    // bit phase within nibble

   assign slave_start = (timing == DTP_SLAVE) & frame_reference_in & ~fref_q; // see R19
   assign pos_d = (slave_start || pos_q == dtp_pkg::FRAME_LAST) ? 13'h0000 : // see R20
                  pos_q + 13'h0001;
   assign blk_d = (pos_d == 13'h0000 || blk_q == dtp_pkg::BLOCK_LAST) ? 7'h00 :
                  blk_q + 7'h01;
   assign is_payload = ~dtp_is_oh(blk_d);
   assign pidx   = (pos_d == 13'h0000) ? 13'h0000 : pc_q;
   assign nphase = pidx[1:0];

   // counters start at the frame's last bit so the first strobe opens a frame
   always_ff @(posedge pclk or negedge presetn) begin // see R20
      if (!presetn) begin
         pos_q  <= dtp_pkg::FRAME_LAST;
         blk_q  <= dtp_pkg::BLOCK_LAST;
         pc_q   <= 13'h0000;
         fref_q <= 1'b0;
      end else if (soft_rst) begin
         pos_q  <= dtp_pkg::FRAME_LAST;
         blk_q  <= dtp_pkg::BLOCK_LAST;
         pc_q   <= 13'h0000;
      end else if (bit_strobe) begin
         pos_q  <= pos_d;
         blk_q  <= blk_d;
         pc_q   <= pidx + {12'h000, is_payload};
         fref_q <= frame_reference_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // serial indicators and capture

   // frame end and warning hold for a whole bit period between strobes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_end_pulse_out <= 1'b0;
         overhead_warn_out   <= 1'b0;
      end else if (soft_rst || nib_mode) begin // pulled low in nibble mode, see R13
         frame_end_pulse_out <= 1'b0;
         overhead_warn_out   <= 1'b0;
      end else if (bit_strobe) begin
         frame_end_pulse_out <= serial_mode & (pos_d == dtp_pkg::FRAME_LAST); // see R9
         overhead_warn_out   <= serial_mode & (blk_d == dtp_pkg::BLOCK_LAST); // see R11
      end
   end

   // payload bits only; the far end withholds data in overhead slots
   always_ff @(posedge pclk or negedge presetn) begin // see R7 see R12
      if (!presetn) begin
         payload_bit_out   <= 1'b0;
         payload_valid_out <= 1'b0;
      end else begin
         payload_valid_out <= bit_strobe & serial_mode & is_payload & ~soft_rst;
         if (bit_strobe & serial_mode & is_payload)
            payload_bit_out <= serial_payload_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // nibble clock, capture and frame end

   // clock rises at each nibble's first payload bit: 1176 rises per frame
   always_ff @(posedge pclk or negedge presetn) begin // see R16 see R17 see R18
      if (!presetn) begin
         nibble_clock_out     <= 1'b0;
         nibble_frame_end_out <= 1'b0;
         nibble_data_out      <= 4'h0;
         nibble_valid_out     <= 1'b0;
      end else begin
         nibble_valid_out <= 1'b0;
         if (soft_rst || !nib_mode) begin
            nibble_clock_out     <= 1'b0;
            nibble_frame_end_out <= 1'b0;
         end else if (bit_strobe && is_payload) begin
            nibble_frame_end_out <= (pidx >= dtp_pkg::NIB_LAST_START);
            if (nphase == 2'h0) begin
               nibble_clock_out <= 1'b1;
               nibble_data_out  <= nibble_payload_in;
               nibble_valid_out <= 1'b1;
            end else if (nphase == dtp_pkg::NIB_PHASE_LOW) begin
               nibble_clock_out <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // apb slave: one wait-free access phase, pready registered

   logic        setup_ph;   // setup cycle seen
   logic        hit_mode;   // mode register addressed
   logic        hit_status; // status register addressed
   logic        wr_en;      // write commits this edge
   logic [31:0] status_w;   // status word

   assign setup_ph   = psel & ~penable;
   assign hit_mode   = (paddr == dtp_pkg::MODE_OFFSET);
   assign hit_status = (paddr == dtp_pkg::STATUS_OFFSET);
   assign wr_en      = psel & penable & pready & pwrite & hit_mode;
   assign status_w   = {13'h0000, (timing == DTP_SLAVE), nib_mode, (timing == DTP_LOOP),
                        3'h0, pos_q};

   // answer raised in the cycle after setup, read data sampled from setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= setup_ph;
         pslverr <= setup_ph & ~hit_mode & ~hit_status;
         prdata  <= (setup_ph & ~pwrite & hit_mode)   ? {24'h000000, mode_q} :
                    (setup_ph & ~pwrite & hit_status) ? status_w : 32'h0000_0000;
      end
   end

   // all eight mode bits are read/write
   always_ff @(posedge pclk or negedge presetn) begin // see R14
      if (!presetn)   mode_q <= dtp_pkg::MODE_RESET;
      else if (wr_en) mode_q <= pwdata[7:0];
   end

   ////////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking dtp_cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_MODE_WRITE: assert property (wr_en |=> mode_q == $past(pwdata[7:0])) // see R14
      else $error("mode register did not take written value");
   AST_LOOP_IGNORES_LOCAL: assert property ( // see R4
      (timing == DTP_LOOP) && $rose(local_timing_clock_in) && !$rose(recovered_line_clock_in)
      |-> !bit_strobe) else $error("local clock produced a strobe in loop timing");
   AST_LOOP_STROBE_SRC: assert property ( // see R3
      (timing == DTP_LOOP) && bit_strobe |-> $rose(recovered_line_clock_in))
      else $error("loop strobe not from line clock");
   AST_LOOP_CLK_FWD: assert property ( // see R5
      (timing == DTP_LOOP) ##1 (timing == DTP_LOOP)
      |-> loop_timed_clock_out == $past(recovered_line_clock_in))
      else $error("forwarded clock does not follow line clock");
   AST_FRAME_END_POS: assert property ( // see R9
      $rose(frame_end_pulse_out) |-> pos_q == dtp_pkg::FRAME_LAST && serial_mode)
      else $error("frame end not at last bit");
   AST_WARN_BEFORE_OH: assert property ( // see R11
      overhead_warn_out && bit_strobe && !soft_rst && !slave_start |=> blk_q == 7'h00)
      else $error("overhead did not follow warning");
   AST_SERIAL_CAPTURE: assert property ( // see R7
      bit_strobe && serial_mode && is_payload && !soft_rst
      |=> payload_valid_out && payload_bit_out == $past(serial_payload_in))
      else $error("serial payload not captured");
   AST_SLAVE_RESTART: assert property ( // see R19
      slave_start && bit_strobe && !soft_rst |=> pos_q == 13'h0000 ##0 blk_q == 7'h00)
      else $error("slave frame did not restart on reference");
   AST_NIB_CAPTURE: assert property ( // see R16
      $rose(nibble_clock_out) |-> nibble_valid_out && nib_mode)
      else $error("nibble clock rose without capture");

   // frame end lasts one bit; serial indicators silent in nibble mode
   AST_FRAME_END_ONE_BIT: assert property ( // see R9
      frame_end_pulse_out && bit_strobe && !soft_rst |=> !frame_end_pulse_out)
      else $error("frame end lasted more than one bit");
   AST_NIB_SERIAL_QUIET: assert property ( // see R13
      nib_mode |=> !frame_end_pulse_out && !overhead_warn_out)
      else $error("serial indicator active in nibble mode");
   // nibble clock rises on a nibble's first bit; frame end over the last nibble
   AST_NIB_CLK_PHASE: assert property ( // see R17
      $rose(nibble_clock_out) |-> pc_q[1:0] == 2'h1)
      else $error("nibble clock rose off a nibble boundary");
   AST_NIB_FRAME_END_POS: assert property ( // see R18
      $rose(nibble_frame_end_out) |-> pc_q > dtp_pkg::NIB_LAST_START)
      else $error("nibble frame end before the last nibble");

   COV_LOOP_FRAME_END: cover property ((timing == DTP_LOOP) && $rose(frame_end_pulse_out));
   COV_SLAVE_RESTART:  cover property (slave_start && bit_strobe && pos_q != dtp_pkg::FRAME_LAST);
   COV_NIB_FRAME_END:  cover property ($rose(nibble_frame_end_out));
   COV_MASTER_STROBE:  cover property ((timing == DTP_MASTER) && bit_strobe);
   COV_NIB_SWITCH:     cover property ($rose(nib_mode));

endmodule : dtp_payload_port

// ### sim/dtp_term_model.sv
// partner: terminal equipment model, clock sources and serial payload source
module dtp_term_model (
   input  wire logic pclk,      // bench clock used to pace the model
   input  wire logic presetn,   // async reset, active low
   input  wire logic loop_clk,  // forwarded interface clock from the port
   input  wire logic warn,      // overhead warning from the port
   input  wire logic frame_end, // frame end pulse from the port
   output logic      line_clk,  // recovered line clock toward the port
   output logic      local_clk, // local timing clock toward the port
   output logic      ser_out    // serial payload toward the port
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] line_div_q; // four pclk per line bit
   logic [2:0] loc_div_q;  // six pclk per local bit, unrelated to line rate
   logic       lc_q;       // last forwarded clock level
   logic [7:0] cnt_q;      // payload pattern position
   ////////////////////////////////////////////////////////////////////////////
   assign line_clk  = line_div_q[1];
   assign local_clk = (loc_div_q > 3'h2);
   assign ser_out   = cnt_q[0] ^ cnt_q[3]; // irregular pattern, not a plain toggle
   // clocks run free; data moves only on a forwarded clock rise
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_div_q <= 2'h0;
         loc_div_q  <= 3'h0;
         lc_q       <= 1'b0;
         cnt_q      <= 8'h00;
      end else begin
         line_div_q <= line_div_q + 2'h1;
         loc_div_q  <= (loc_div_q == 3'h5) ? 3'h0 : loc_div_q + 3'h1;
         lc_q       <= loop_clk;
         if (loop_clk && !lc_q) begin // shared clock, change on its rise
            if (frame_end) begin // restart next frame
               cnt_q <= 8'h00;
            end else if (!warn) begin // hold one cycle for overhead
               cnt_q <= cnt_q + 8'h01;
            end
         end
      end
   end
endmodule : dtp_term_model

// ### sim/dtp_payload_port_tb_top.sv
// testbench: registers, loop-timed serial, nibble and frame slave scenarios
module dtp_payload_port_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        pclk = 1'b0;      // 10 mhz bench clock
   logic        presetn = 1'b0;   // async reset, active low
   logic        psel = 1'b0;      // apb select
   logic        penable = 1'b0;   // apb enable
   logic        pwrite = 1'b0;    // apb direction
   logic [7:0]  paddr = 8'h00;    // apb address
   logic [31:0] pwdata = 32'h0;   // apb write data
   logic        nib_sel = 1'b0;   // serial when low
   logic        frame_ref = 1'b0; // frame reference toward the port
   logic [31:0] prdata;
   logic        pready, pslverr, line_clk, local_clk, ser;
   logic        loop_clk, fe, warn, nclk, nfe, pbit, pval, nval;
   logic [3:0]  ndata;
   logic [3:0]  nib_in;           // nibble payload toward the port, follows serial data
   assign nib_in = {ser, 1'b0, ~ser, 1'b1};
   int          error_cnt = 0;    // mismatches seen
   int          tests_run = 0;    // comparisons made
   ////////////////////////////////////////////////////////////////////////////
   dtp_payload_port dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .recovered_line_clock_in(line_clk), .local_timing_clock_in(local_clk),
      .nibble_mode_select_pin(nib_sel), .serial_payload_in(ser), .nibble_payload_in(nib_in),
      .frame_reference_in(frame_ref), .loop_timed_clock_out(loop_clk),
      .frame_end_pulse_out(fe), .overhead_warn_out(warn), .nibble_clock_out(nclk),
      .nibble_frame_end_out(nfe), .payload_bit_out(pbit), .payload_valid_out(pval),
      .nibble_data_out(ndata), .nibble_valid_out(nval));
   dtp_term_model term_u (.pclk(pclk), .presetn(presetn), .loop_clk(loop_clk), .warn(warn),
      .frame_end(fe), .line_clk(line_clk), .local_clk(local_clk), .ser_out(ser));
   always #50 pclk = ~pclk;
   ////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : report_and_stop
   // compare and count
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   // one apb transfer; holds the request until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         error_cnt++;
         report_and_stop();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // reset value, field access, read-only and unmapped places
   task automatic test_regs;
      logic [31:0] rd;
      logic        err;
      apb(1'b0, dtp_pkg::MODE_OFFSET, 32'h0, rd, err);
      chk("mode_reset", {24'h0, dtp_pkg::MODE_RESET}, rd);
      apb(1'b1, dtp_pkg::MODE_OFFSET, 32'hFFFFFF5A, rd, err); // loopback kept clear
      apb(1'b0, dtp_pkg::MODE_OFFSET, 32'h0, rd, err);
      chk("mode_rw", 32'h0000005A, rd);
      apb(1'b1, dtp_pkg::STATUS_OFFSET, 32'hFFFFFFFF, rd, err);
      chk("status_wr_err", 32'h0, {31'h0, err});
      apb(1'b0, 8'h08, 32'h0, rd, err);
      chk("unmapped_err", 32'h1, {31'h0, err});
      chk("unmapped_data", 32'h0, rd);
      apb(1'b1, dtp_pkg::MODE_OFFSET, 32'h0, rd, err); // loop code 00
      apb(1'b0, dtp_pkg::STATUS_OFFSET, 32'h0, rd, err);
      chk("status_loop", 32'h1, {31'h0, rd[dtp_pkg::ST_LOOP_BIT]});
      $display("test regs finished");
   endtask : test_regs
   // one whole serial frame in loop timing
   task automatic test_serial;
      int   n, ph, strb, warns, vals, fe_hi, bad_clk, bad_cap;
      logic pl, pw, pf, ser_s, warn_end;
      {ph, strb, warns, vals, fe_hi, bad_clk, bad_cap} = '0;
      {pl, pw, pf, ser_s, warn_end} = '0;
      @(posedge pclk);
      pl = line_clk;
      ser_s = ser; // a strobe on this edge is judged on the first pass
      for (n = 0; n < 45000 && ph < 2; n++) begin
         @(posedge pclk);
         if (loop_clk !== pl) bad_clk++;
         if (pval === 1'b1 && pbit !== ser_s) bad_cap++;
         if (line_clk && !pl) ser_s = ser;
         if (fe === 1'b1 && !pf) begin
            if (ph == 1) warn_end = warn;
            ph++;
         end
         if (ph == 1) begin
            if (line_clk && !pl) strb++;
            if (warn === 1'b1 && !pw) warns++;
            if (pval === 1'b1) vals++;
            if (fe === 1'b1) fe_hi++;
         end
         pl = line_clk;
         pw = warn;
         pf = fe;
      end
      chk("frame_seen", 32'd2, ph);
      chk("loop_clk_copy", 32'd0, bad_clk);
      chk("capture", 32'd0, bad_cap);
      chk("bits_per_frame", {19'h0, dtp_pkg::FRAME_BITS}, strb);
      chk("warn_count", {19'h0, dtp_pkg::FRAME_BITS - dtp_pkg::PAYLOAD_BITS}, warns);
      chk("payload_count", {19'h0, dtp_pkg::PAYLOAD_BITS}, vals);
      chk("frame_end_width", 32'd4, fe_hi);
      chk("warn_at_end", 32'h1, {31'h0, warn_end});
      if (ph < 2) report_and_stop(); // frames never closed: timed out
      $display("test serial finished");
   endtask : test_serial
   // one whole frame in nibble mode
   task automatic test_nibble;
      int   n, ph, rises, ser_hi, bad_nib;
      logic pc, pf, pl;
      logic [3:0] nib_s;
      {ph, rises, ser_hi, bad_nib, pc, pf} = '0;
      nib_sel <= 1'b1;
      @(posedge pclk); // serial indicators are registered: they drop one edge later
      pl = line_clk;
      nib_s = nib_in;
      for (n = 0; n < 45000 && ph < 2; n++) begin
         @(posedge pclk);
         if (nval === 1'b1 && ndata !== nib_s) bad_nib++;
         if (line_clk && !pl) nib_s = nib_in;
         pl = line_clk;
         if (fe !== 1'b0 || warn !== 1'b0) ser_hi++;
         if (nfe === 1'b1 && !pf) ph++;
         if (ph == 1 && nclk === 1'b1 && !pc) rises++;
         pc = nclk;
         pf = nfe;
      end
      chk("nib_frame_seen", 32'd2, ph);
      chk("nib_clock_rises", {19'h0, dtp_pkg::NIBBLES}, rises);
      chk("nib_capture", 32'd0, bad_nib);
      chk("serial_outs_low", 32'd0, ser_hi);
      if (ph < 2) report_and_stop(); // frames never closed: timed out
      nib_sel <= 1'b0;
      $display("test nibble finished");
   endtask : test_nibble
   // frame slave: reference rise opens bit 0
   task automatic test_slave;
      logic [31:0] rd;
      logic        err, pl;
      int          n;
      apb(1'b1, dtp_pkg::MODE_OFFSET, 32'h00000001, rd, err); // slave code
      pl = 1'b1;
      for (n = 0; n < 50 && !(local_clk && !pl); n++) begin
         pl = local_clk;
         @(posedge pclk);
      end
      if (n >= 50) begin
         error_cnt++;
         report_and_stop();
      end
      frame_ref <= 1'b1;
      repeat (6) @(posedge pclk);
      frame_ref <= 1'b0;
      apb(1'b0, dtp_pkg::STATUS_OFFSET, 32'h0, rd, err);
      chk("slave_pos", 32'h0, {19'h0, rd[dtp_pkg::ST_POS_MSB:0]});
      chk("slave_flag", 32'h1, {31'h0, rd[dtp_pkg::ST_SLAVE_BIT]});
      chk("loop_clk_off", 32'h0, {31'h0, loop_clk});
      $display("test slave finished");
   endtask : test_slave
   // main sequence
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      test_regs();
      test_serial();
      test_nibble();
      test_slave();
      report_and_stop();
   end
endmodule : dtp_payload_port_tb_top
